// ==== inc/sz_map.svh ====
// Constants of the four-lane word serializer: widths, counts, reset values.
// Assumes inclusion by the package and the design modules only.
`ifndef SZ_MAP_SVH
`define SZ_MAP_SVH

// ********************************
// Word and lane layout
// ********************************
`define SZ_WORD_BITS 28
`define SZ_LANES 4
`define SZ_SLICE_BITS 7
`define SZ_LAST_BIT 3'h6

// ********************************
// Forwarded clock shape
// ********************************
`define SZ_FWD_HIGH_BITS 3'h4

// ********************************
// Lock detection
// ********************************
`define SZ_LOCK_PERIODS 4
`define SZ_PERIOD_W 10
`define SZ_PERIOD_TOL 1

// ********************************
// Buffer
// ********************************
`define SZ_BUF_DEPTH 2

// ********************************
// Reset values
// ********************************
`define SZ_WORD_RST 28'h0000000
`define SZ_SLICE_RST 7'h00

`endif

// ==== inc/sz_pkg.sv ====
// Types shared by the serializer and its self-checking bench.
// Assumes sz_map.svh on the include path.
`include "sz_map.svh"

package sz_pkg;

  // ********************************
  // Data types
  // ********************************
  typedef logic [`SZ_WORD_BITS-1:0] sz_word_t;

  typedef logic [`SZ_SLICE_BITS-1:0] sz_slice_t;

  typedef enum logic [1:0] {
    SZ_UNLOCKED = 2'h0,
    SZ_ACQUIRE = 2'h1,
    SZ_LOCKED = 2'h3
  } sz_lock_t;

  typedef struct packed {
    logic [`SZ_LANES-1:0] pos;
    logic [`SZ_LANES-1:0] neg;
    logic clk_pos;
    logic clk_neg;
    logic drive_en;
  } sz_lvds_t;

endpackage

// ==== verilog/sz_pair_buf.sv ====
// Small word buffer with valid and ready on both sides.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ps
`include "sz_map.svh"

module sz_pair_buf #(
  parameter int WIDTH = `SZ_WORD_BITS,
  parameter int DEPTH = `SZ_BUF_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] ptr_next(input logic [AW-1:0] p);
    ptr_next = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // ********************************
  // Storage
  // ********************************
  // Cleared too, so no word outlives a shutdown
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0; // RULE8
      end
    end else if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // ********************************
  // Pointers and fill level
  // ********************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= ptr_next(wr_q);
      end
      if (pop) begin
        rd_q <= ptr_next(rd_q);
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

endmodule

// ==== verilog/sz_serializer.sv ====
// Four-lane word serializer with forwarded clock.
// Assumes the word clock comes from the upstream source with data and
// edge select synchronous to it; clk_sys is free-running and much faster.
//
// Functional notes
// (RULE1) Every selected word-clock edge captures all 28 parallel bits.
// (RULE2) Edge select high picks rising edge, low picks falling; held static.
// (RULE3) Four seven-bit parallel-load, serial-out shift registers hold the word.
// (RULE4) Seven bit ticks per word period shift one seven-bit slice out.
// (RULE5) Four serial streams plus forwarded clock drive five differential lanes.
// (RULE6) Forwarded clock matches word clock frequency, phase-locked to it.
// (RULE7) Shutdown low stops internal clocking and turns lane drivers off.
// (RULE8) Shutdown low asynchronously clears every internal register.
// (RULE9) Upstream keeps word clock inside the multiplier's lock range.
// (RULE10) Bit position zero starts at forwarded clock rise; bits spaced period/7.
// (RULE11) Fixed bit-to-lane map shared with the matching receiver.
// (RULE12) After shutdown, lanes carry zeros until the multiplier relocks.
`timescale 1ns/1ps
`include "sz_map.svh"

module sz_serializer #(
  parameter int PERIOD_W = `SZ_PERIOD_W,
  parameter int LOCK_PERIODS = `SZ_LOCK_PERIODS
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic input_word_clock,
  input wire logic capture_edge_select,
  input wire logic shutdown_clear_n,
  input wire sz_pkg::sz_word_t parallel_bits,
  output logic serial_lane_a_pos,
  output logic serial_lane_a_neg,
  output logic serial_lane_b_pos,
  output logic serial_lane_b_neg,
  output logic serial_lane_c_pos,
  output logic serial_lane_c_neg,
  output logic serial_lane_d_pos,
  output logic serial_lane_d_neg,
  output logic forwarded_lane_clock_pos,
  output logic forwarded_lane_clock_neg,
  output logic lane_drive_en,
  output logic link_locked,
  output logic word_accept_ready
);
  import sz_pkg::*;

  // ********************************
  // Declarations
  // ********************************
  logic rst_any;
  logic sel_meta_q;
  logic sel_q;
  sz_word_t rise_word_q;
  sz_word_t fall_word_q;
  logic rise_tgl_q;
  logic fall_tgl_q;
  logic [2:0] rise_sync_q;
  logic [2:0] fall_sync_q;
  logic [1:0] pwr_q;
  logic rise_evt;
  logic fall_evt;
  logic word_evt;
  sz_word_t evt_word;
  logic [PERIOD_W-1:0] per_cnt_q;
  logic [PERIOD_W-1:0] per_q;
  logic per_close;
  logic per_stalled;
  sz_lock_t lock_q;
  logic [3:0] lock_cnt_q;
  logic locked;
  logic [PERIOD_W:0] acc_q;
  logic [PERIOD_W:0] acc_sum;
  logic tick;
  logic [2:0] bit_idx_q;
  sz_slice_t [`SZ_LANES-1:0] shreg_q;
  sz_lvds_t lvds_q;
  logic buf_in_valid;
  logic buf_out_valid;
  logic buf_out_ready;
  sz_word_t buf_out_data;

  // ********************************
  // Helpers
  // ********************************
  // Lane k carries word bits 7k..7k+6, bit 7k sent first
  function automatic sz_slice_t lane_slice(input sz_word_t w, input int k);
    lane_slice = w[k*`SZ_SLICE_BITS +: `SZ_SLICE_BITS];
  endfunction

  function automatic logic near_equal(input logic [PERIOD_W-1:0] a,
                                      input logic [PERIOD_W-1:0] b);
    logic [PERIOD_W-1:0] diff;
    diff = (a > b) ? PERIOD_W'(a - b) : PERIOD_W'(b - a);
    near_equal = (diff <= PERIOD_W'(`SZ_PERIOD_TOL));
  endfunction

  // Pin-driven clear joins the system reset; assertion is asynchronous
  assign rst_any = sys_rst | ~shutdown_clear_n; // RULE8

  // ********************************
  // Word clock domain: capture
  // ********************************
  // Edge select is static, so a plain two-stage sync is enough
  always_ff @(posedge input_word_clock or posedge rst_any) begin
    if (rst_any) begin
      sel_meta_q <= 1'b0;
      sel_q <= 1'b0;
    end else begin
      sel_meta_q <= capture_edge_select;
      sel_q <= sel_meta_q;
    end
  end

  always_ff @(posedge input_word_clock or posedge rst_any) begin
    if (rst_any) begin
      rise_word_q <= `SZ_WORD_RST; // RULE8
      rise_tgl_q <= 1'b0;
    end else if (sel_q) begin
      rise_word_q <= parallel_bits; // RULE1 RULE2
      rise_tgl_q <= ~rise_tgl_q;
    end
  end

  always_ff @(negedge input_word_clock or posedge rst_any) begin
    if (rst_any) begin
      fall_word_q <= `SZ_WORD_RST; // RULE8
      fall_tgl_q <= 1'b0;
    end else if (!sel_q) begin
      fall_word_q <= parallel_bits; // RULE1 RULE2
      fall_tgl_q <= ~fall_tgl_q;
    end
  end

  // ********************************
  // Crossing into clk_sys
  // ********************************
  // Words stay put a full word period, long after the toggle lands
  always_ff @(posedge clk_sys or posedge rst_any) begin
    if (rst_any) begin
      rise_sync_q <= 3'h0;
      fall_sync_q <= 3'h0;
    end else begin
      rise_sync_q <= {rise_sync_q[1:0], rise_tgl_q};
      fall_sync_q <= {fall_sync_q[1:0], fall_tgl_q};
    end
  end

  assign rise_evt = rise_sync_q[2] ^ rise_sync_q[1];
  assign fall_evt = fall_sync_q[2] ^ fall_sync_q[1];
  assign word_evt = rise_evt | fall_evt;
  assign evt_word = rise_evt ? rise_word_q : fall_word_q;

  // Drivers come up three edges after shutdown is released
  always_ff @(posedge clk_sys or posedge rst_any) begin
    if (rst_any) begin
      pwr_q <= 2'h0;
    end else begin
      pwr_q <= {pwr_q[0], 1'b1}; // RULE7
    end
  end

  // ********************************
  // Period measurement
  // ********************************
  assign per_close = near_equal(per_cnt_q, per_q);
  assign per_stalled = (per_cnt_q == {PERIOD_W{1'b1}});

  always_ff @(posedge clk_sys or posedge rst_any) begin
    if (rst_any) begin
      per_cnt_q <= '0;
      per_q <= '0;
    end else if (word_evt) begin
      per_cnt_q <= PERIOD_W'(1);
      per_q <= per_cnt_q;
    end else if (!per_stalled) begin
      per_cnt_q <= per_cnt_q + 1'b1;
    end
  end

  // ********************************
  // Lock tracking
  // ********************************
  // A jumping period drops lock at once; a stopped word clock drops it when the period count saturates
  always_ff @(posedge clk_sys or posedge rst_any) begin
    if (rst_any) begin
      lock_q <= SZ_UNLOCKED; // RULE12
      lock_cnt_q <= 4'h0;
    end else if (per_stalled) begin
      lock_q <= SZ_UNLOCKED;
      lock_cnt_q <= 4'h0;
    end else if (word_evt) begin
      unique case (lock_q)
        SZ_UNLOCKED: begin
          lock_q <= SZ_ACQUIRE;
          lock_cnt_q <= 4'h0;
        end
        SZ_ACQUIRE: begin
          if (!per_close) begin
            lock_cnt_q <= 4'h0;
          end else if (lock_cnt_q == 4'(LOCK_PERIODS - 1)) begin
            lock_q <= SZ_LOCKED; // RULE12
          end else begin
            lock_cnt_q <= lock_cnt_q + 1'b1;
          end
        end
        SZ_LOCKED: begin
          if (!per_close) begin
            lock_q <= SZ_UNLOCKED;
          end
        end
        default: begin
          lock_q <= SZ_UNLOCKED;
        end
      endcase
    end
  end

  assign locked = (lock_q == SZ_LOCKED);

  // ********************************
  // Bit tick synthesis
  // ********************************
  // Adds 7 per cycle against the period: six ticks plus the word-event load per period
  // without a divider, at the cost of up to one cycle of bit jitter
  assign acc_sum = acc_q + (PERIOD_W+1)'(`SZ_SLICE_BITS);
  assign tick = locked && !word_evt && (acc_sum >= {1'b0, per_q});

  always_ff @(posedge clk_sys or posedge rst_any) begin
    if (rst_any) begin
      acc_q <= '0;
    end else if (word_evt || !locked) begin
      acc_q <= '0; // RULE6
    end else if (tick) begin
      acc_q <= acc_sum - {1'b0, per_q}; // RULE4
    end else begin
      acc_q <= acc_sum;
    end
  end

  // ********************************
  // Word buffer
  // ********************************
  // Only words taken while locked enter; a word left buffered at a lock loss is sent after relock, and shutdown clears it
  assign buf_in_valid = word_evt && locked; // RULE12
  assign buf_out_ready = word_evt && locked;

  sz_pair_buf #(
    .WIDTH(`SZ_WORD_BITS),
    .DEPTH(`SZ_BUF_DEPTH)
  ) u_buf (
    .clk(clk_sys),
    .rst(rst_any),
    .in_valid(buf_in_valid),
    .in_ready(word_accept_ready),
    .in_data(evt_word),
    .out_valid(buf_out_valid),
    .out_ready(buf_out_ready),
    .out_data(buf_out_data)
  );

  // ********************************
  // Shift registers
  // ********************************
  // Slice restarts on every word event, so the slice frame follows the word clock
  always_ff @(posedge clk_sys or posedge rst_any) begin
    if (rst_any) begin
      bit_idx_q <= 3'h0;
      shreg_q <= '0; // RULE8
    end else if (!locked) begin
      bit_idx_q <= 3'h0;
      shreg_q <= '0; // RULE12
    end else if (word_evt) begin
      bit_idx_q <= 3'h0; // RULE10
      for (int k = 0; k < `SZ_LANES; k++) begin
        shreg_q[k] <= buf_out_valid ? lane_slice(buf_out_data, k) : `SZ_SLICE_RST; // RULE3 RULE11
      end
    end else if (tick && (bit_idx_q != `SZ_LAST_BIT)) begin
      bit_idx_q <= bit_idx_q + 1'b1; // RULE4
      for (int k = 0; k < `SZ_LANES; k++) begin
        shreg_q[k] <= {1'b0, shreg_q[k][`SZ_SLICE_BITS-1:1]}; // RULE3
      end
    end
  end

  // ********************************
  // Lane drivers
  // ********************************
  // With drivers off both legs sit low, standing in for a floating pair
  always_ff @(posedge clk_sys or posedge rst_any) begin
    if (rst_any) begin
      lvds_q <= '0; // RULE7
    end else begin
      lvds_q.drive_en <= pwr_q[1]; // RULE7
      for (int k = 0; k < `SZ_LANES; k++) begin
        lvds_q.pos[k] <= pwr_q[1] & shreg_q[k][0]; // RULE5
        lvds_q.neg[k] <= pwr_q[1] & ~shreg_q[k][0]; // RULE5
      end
      lvds_q.clk_pos <= pwr_q[1] & locked & (bit_idx_q < `SZ_FWD_HIGH_BITS); // RULE6 RULE10
      lvds_q.clk_neg <= pwr_q[1] & ~(locked & (bit_idx_q < `SZ_FWD_HIGH_BITS)); // RULE6
    end
  end

  assign serial_lane_a_pos = lvds_q.pos[0];
  assign serial_lane_a_neg = lvds_q.neg[0];
  assign serial_lane_b_pos = lvds_q.pos[1];
  assign serial_lane_b_neg = lvds_q.neg[1];
  assign serial_lane_c_pos = lvds_q.pos[2];
  assign serial_lane_c_neg = lvds_q.neg[2];
  assign serial_lane_d_pos = lvds_q.pos[3];
  assign serial_lane_d_neg = lvds_q.neg[3];
  assign forwarded_lane_clock_pos = lvds_q.clk_pos;
  assign forwarded_lane_clock_neg = lvds_q.clk_neg;
  assign lane_drive_en = lvds_q.drive_en;
  assign link_locked = locked;

endmodule

// ==== tb/sz_monitor.sv ====
// Port-level checks on the four-lane serializer.
// Assumes a steady word clock of WORD_CYC system cycles while locked.
`timescale 1ns/1ps

module sz_monitor #(
  parameter int WORD_CYC = 16
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic shutdown_clear_n,
  input wire logic serial_lane_a_pos,
  input wire logic serial_lane_a_neg,
  input wire logic serial_lane_b_pos,
  input wire logic serial_lane_b_neg,
  input wire logic serial_lane_c_pos,
  input wire logic serial_lane_c_neg,
  input wire logic serial_lane_d_pos,
  input wire logic serial_lane_d_neg,
  input wire logic forwarded_lane_clock_pos,
  input wire logic forwarded_lane_clock_neg,
  input wire logic lane_drive_en,
  input wire logic link_locked,
  input wire logic word_accept_ready
);
  wire [3:0] lp = {serial_lane_d_pos, serial_lane_c_pos, serial_lane_b_pos, serial_lane_a_pos};
  wire [3:0] ln = {serial_lane_d_neg, serial_lane_c_neg, serial_lane_b_neg, serial_lane_a_neg};
  logic fwd_q;
  logic seen_q;
  logic [10:0] gap_q;
  wire fwd_rise = forwarded_lane_clock_pos & ~fwd_q;

  // ****************
  // Forwarded clock period counter
  // ****************
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      fwd_q <= 1'b0;
      seen_q <= 1'b0;
      gap_q <= 11'h000;
    end else begin
      fwd_q <= forwarded_lane_clock_pos;
      seen_q <= link_locked & (seen_q | fwd_rise);
      gap_q <= fwd_rise ? 11'h001 : gap_q + 11'h001;
    end
  end

  // ****************
  // Assertions
  // ****************
  sequence s_fwd_high;
    forwarded_lane_clock_pos [*6] ##[1:5] !forwarded_lane_clock_pos;
  endsequence

  chk_off_cleared: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !shutdown_clear_n |-> !lane_drive_en && lp == 4'h0 && ln == 4'h0
      && !forwarded_lane_clock_pos && !forwarded_lane_clock_neg)
    else $error("lanes active during shutdown");
  chk_off_unlocked: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !shutdown_clear_n |-> !link_locked && word_accept_ready)
    else $error("state not cleared during shutdown");
  chk_drive_wakes: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(shutdown_clear_n) |-> ##[1:4] lane_drive_en)
    else $error("drivers did not return after shutdown");
  chk_legs_opposite: assert property (@(posedge clk_sys) disable iff (sys_rst)
    lane_drive_en |-> ln == ~lp && forwarded_lane_clock_neg == !forwarded_lane_clock_pos)
    else $error("differential legs not complementary");
  chk_idle_zero: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !link_locked [*3] |-> lp == 4'h0 && !forwarded_lane_clock_pos)
    else $error("data sent before lock");
  chk_fwd_shape: assert property (@(posedge clk_sys)
    disable iff (sys_rst || !shutdown_clear_n)
    $rose(forwarded_lane_clock_pos) |-> s_fwd_high)
    else $error("forwarded clock high phase wrong");
  chk_fwd_period: assert property (@(posedge clk_sys) disable iff (sys_rst)
    fwd_rise && seen_q |-> gap_q inside {[WORD_CYC - 1:WORD_CYC + 1]})
    else $error("forwarded clock period differs from word clock");
  chk_ready_locked: assert property (@(posedge clk_sys) disable iff (sys_rst)
    link_locked |-> word_accept_ready)
    else $error("word buffer full at steady rate");
endmodule

// ==== tb/sz_rx_model.sv ====
// Behavioural seven-to-one receiver recovering words from the lanes.
// Assumes a word period of WORD_CYC system cycles; samples mid-bit.
`timescale 1ns/1ps

module sz_rx_model #(
  parameter int WORD_CYC = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] lane_pos,
  input wire logic fwd_pos,
  output logic [27:0] rx_word
);
  logic fwd_q;
  logic [9:0] cnt_q;
  logic [2:0] bit_q;
  // Mid-bit point lies (2*bit+1)*WORD_CYC/14 cycles, rounded down, after the forwarded clock rise
  wire [9:0] mid = 10'((2 * int'(bit_q) + 1) * WORD_CYC / 14);

  // ****************
  // Slice recovery
  // ****************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fwd_q <= 1'b0;
      cnt_q <= 10'h000;
      bit_q <= 3'h7;
      rx_word <= 28'h0000000;
    end else begin
      fwd_q <= fwd_pos;
      if (fwd_pos && !fwd_q) begin
        cnt_q <= 10'h001;
        bit_q <= 3'h0;
      end else begin
        cnt_q <= cnt_q + 10'h001;
        if (bit_q != 3'h7 && cnt_q == mid) begin
          for (int l = 0; l < 4; l++) begin
            rx_word[l * 7 + int'(bit_q)] <= lane_pos[l];
          end
          bit_q <= bit_q + 3'h1;
        end
      end
    end
  end
endmodule

// ==== tb/sz_serializer_bench.sv ====
// Self-checking bench for the four-lane serializer.
// Assumes the receiver model and the port monitor beside it.
`timescale 1ns/1ps

module sz_serializer_bench;
  import sz_pkg::*;
  localparam int WORD_CYC = 16;
  logic clk_sys, sys_rst, input_word_clock, capture_edge_select, shutdown_clear_n;
  sz_word_t parallel_bits;
  sz_word_t held;
  logic [3:0] lp;
  logic [3:0] ln;
  logic fp, fn, lane_drive_en, link_locked, word_accept_ready;
  logic [27:0] rx_word;
  logic [31:0] rng;
  int mismatches;
  int n_checks;

  sz_serializer dut_u (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .input_word_clock(input_word_clock),
    .capture_edge_select(capture_edge_select), .shutdown_clear_n(shutdown_clear_n),
    .parallel_bits(parallel_bits),
    .serial_lane_a_pos(lp[0]), .serial_lane_a_neg(ln[0]),
    .serial_lane_b_pos(lp[1]), .serial_lane_b_neg(ln[1]),
    .serial_lane_c_pos(lp[2]), .serial_lane_c_neg(ln[2]),
    .serial_lane_d_pos(lp[3]), .serial_lane_d_neg(ln[3]),
    .forwarded_lane_clock_pos(fp), .forwarded_lane_clock_neg(fn),
    .lane_drive_en(lane_drive_en), .link_locked(link_locked),
    .word_accept_ready(word_accept_ready)
  );
  sz_rx_model #(.WORD_CYC(WORD_CYC)) rx_u (
    .clk_sys(clk_sys), .rst(sys_rst | ~shutdown_clear_n), .lane_pos(lp), .fwd_pos(fp),
    .rx_word(rx_word)
  );

  // ****************
  // Helpers
  // ****************
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic sz_word_t corner(input int i);
    case (i)
      0: return 28'h0000001;
      1: return 28'h8000000;
      2: return 28'hFFFFFFF;
      default: return 28'h5555555;
    endcase
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic wait_lock();
    int k;
    k = 0;
    while (link_locked !== 1'b1 && k < 400) begin
      @(negedge clk_sys);
      k++;
    end
    check(32'(link_locked), 32'h1);
  endtask

  // Corner words first, then random ones, each held for four periods
  task automatic run_words(input int n);
    for (int i = 0; i < n; i++) begin
      rng = next_rand(rng);
      held = (i < 4) ? corner(i) : rng[27:0];
      repeat (4 * WORD_CYC) @(negedge clk_sys);
      check(32'(rx_word), 32'(held));
    end
  endtask

  // ****************
  // Clocks and data source
  // ****************
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial begin
    input_word_clock = 1'b0;
    #3.7;
    forever #80 input_word_clock = ~input_word_clock;
  end

  // Complement stands at the unselected edge, so a wrong edge shows up
  always begin
    @(input_word_clock);
    repeat (4) @(negedge clk_sys);
    parallel_bits = (input_word_clock == capture_edge_select) ? ~held : held;
  end

  initial begin
    #200000;
    mismatches++;
    print_verdict();
  end

  // ****************
  // Main sequence
  // ****************
  initial begin
    sys_rst = 1'b1;
    capture_edge_select = 1'b1;
    shutdown_clear_n = 1'b1;
    parallel_bits = 28'h0000000;
    held = 28'h0000000;
    rng = 32'h000016B0;
    mismatches = 0;
    n_checks = 0;
    repeat (3) @(negedge clk_sys);
    check(32'({lane_drive_en, link_locked, lp, ln, fp, fn}), 32'h0);
    check(32'(word_accept_ready), 32'h1);
    sys_rst = 1'b0;
    wait_lock();
    run_words(10);
    shutdown_clear_n = 1'b0;
    capture_edge_select = 1'b0;
    #1;
    check(32'({lane_drive_en, link_locked, lp, ln, fp, fn}), 32'h0);
    repeat (3) @(negedge clk_sys);
    shutdown_clear_n = 1'b1;
    repeat (8) @(negedge clk_sys);
    check(32'({link_locked, lp, fp}), 32'h0);
    wait_lock();
    run_words(10);
    print_verdict();
  end
endmodule

bind sz_serializer sz_monitor #(.WORD_CYC(16)) mon_u (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .shutdown_clear_n(shutdown_clear_n),
  .serial_lane_a_pos(serial_lane_a_pos), .serial_lane_a_neg(serial_lane_a_neg),
  .serial_lane_b_pos(serial_lane_b_pos), .serial_lane_b_neg(serial_lane_b_neg),
  .serial_lane_c_pos(serial_lane_c_pos), .serial_lane_c_neg(serial_lane_c_neg),
  .serial_lane_d_pos(serial_lane_d_pos), .serial_lane_d_neg(serial_lane_d_neg),
  .forwarded_lane_clock_pos(forwarded_lane_clock_pos),
  .forwarded_lane_clock_neg(forwarded_lane_clock_neg),
  .lane_drive_en(lane_drive_en), .link_locked(link_locked),
  .word_accept_ready(word_accept_ready)
);
